// ===== rtl/lvds_serdes_lane.sv
// lvds lane: serializer, deserializer, delay chain, phase aligner, rx fifo, apb registers
// Operation
// - full rate moves one bit per clock
// - half rate moves two bits per clock
// - word width programmable up to ten
// - optional eight word receive fifo
// - empty flag while fifo holds nothing
// - read enable pops next stored word
// - receive reset clears fifo and deserializer
// - input buffer follows its enable bit
// - dynamic termination follows its enable bit
// - adjust enable drives delay or aligner
// - direction steps delay up or down
// - adjust reset clears delay or aligner
// - locked flag marks trained receive data
// - aligner centres sampling in bit window
// - bypass output only at width one
// - received word presented at word boundary
// - transmit word taken then serialized
// - transmit reset clears serializer only
// - pad driven only with output enable
// - transmit data or reference clock pattern
// - full or half rate both directions
//
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "lane_cfg.svh"
module lvds_serdes_lane
    import lane_pkg::*;
#(
    parameter int WORD_W = 10,
    parameter int FIFO_DEPTH = 8,
    parameter int DELAY_TAPS = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] rx_pad_in,
    output logic [1:0] tx_pad_out,
    output logic tx_pad_oe,
    output logic bypass_input,
    output logic rx_buffer_on,
    output logic termination_on,
    input wire logic rx_reset,
    input wire logic tx_reset,
    input wire logic delay_adjust_enable,
    input wire logic delay_direction,
    input wire logic delay_adjust_reset,
    input wire logic fifo_read_enable,
    output logic [WORD_W-1:0] rx_data_out,
    output logic rx_word_valid,
    output logic fifo_empty_flag,
    output logic align_locked,
    input wire logic [WORD_W-1:0] tx_data_in,
    output logic tx_word_taken
);
    localparam int PW = $clog2(FIFO_DEPTH);
    localparam int TW = $clog2(DELAY_TAPS);
    localparam logic [TW-1:0] TAP_MAX = TW'(DELAY_TAPS - 1);
    localparam logic [PW:0] FIFO_FULL = (PW + 1)'(FIFO_DEPTH);

    // clamp the programmed width; half rate needs an even count of bits
    function automatic logic [3:0] eff_width(input logic [3:0] f, input logic half);
        logic [3:0] w;
        w = (f == 4'h0 || f > `WORD_MAX) ? `WORD_MAX : f;
        if (half && w[0]) begin
            w = w + 4'h1;
        end
        return w;
    endfunction : eff_width

    // bit position advance; msb of the result marks the word boundary
    function automatic logic [4:0] advance(input logic [3:0] cnt, input logic [3:0] w,
                                           input logic half);
        logic [4:0] n;
        n = {1'b0, cnt} + (half ? 5'h02 : 5'h01);
        if (n >= {1'b0, w}) begin
            return 5'h10;
        end
        return {1'b0, n[3:0]};
    endfunction : advance

    // register address decode, shared by reads and writes
    function automatic reg_sel_t decode(input logic [7:0] a);
        if (a == `LANE_CTRL_OFS) begin
            return SEL_CTRL;
        end else if (a == `LANE_STAT_OFS) begin
            return SEL_STAT;
        end else begin
            return SEL_NONE;
        end
    endfunction : decode

    logic [31:0] ctrl_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic ovf_q;
    logic rx_rst_n;
    logic tx_rst_n;
    logic half;
    logic [3:0] wid;
    logic [WORD_W-1:0] wmask;
    logic [1:0] s1_q;
    logic [1:0] s2_q;
    logic [1:0] s3_q;
    logic [1:0] pad_q;
    logic [1:0] rx_bit;
    logic [1:0] dly_bit;
    logic [TW-1:0] tap_q;
    logic [3:0] rx_cnt_q;
    logic [3:0] rx_cnt_d;
    logic rx_tick;
    logic [WORD_W-1:0] rx_sh_q;
    logic [WORD_W-1:0] rx_sh_d;
    logic [WORD_W-1:0] rx_word;
    align_state_t al_state_q;
    logic locked_q;
    logic found_q;
    logic [TW-1:0] lo_q;
    logic [TW-1:0] hi_q;
    logic [WORD_W-1:0] prev_q;
    logic stable;
    logic found_n;
    logic [TW-1:0] lo_n;
    logic [TW-1:0] hi_n;
    logic [TW:0] mid_sum;
    logic [WORD_W-1:0] mem [FIFO_DEPTH];
    logic [PW-1:0] wr_q;
    logic [PW-1:0] rd_q;
    logic [PW:0] lvl_q;
    logic [PW:0] lvl_d;
    logic push;
    logic pop;
    logic push_ok;
    logic ovf_evt;
    logic [WORD_W-1:0] rx_data_q;
    logic rx_valid_q;
    logic empty_q;
    logic [3:0] tx_cnt_q;
    logic [3:0] tx_cnt_d;
    logic tx_tick;
    logic [WORD_W-1:0] tx_hold_q;
    logic [WORD_W-1:0] refpat;
    logic [1:0] tx_bits;
    logic [1:0] tx_pad_q;
    logic tx_oe_q;
    logic tx_taken_q;
    logic bypass_q;
    logic buf_on_q;
    logic term_on_q;
    logic apb_acc;
    logic apb_done;

    // configuration fields; one width serves both directions
    assign half = ctrl_q[`F_HALF];
    assign wid = eff_width(ctrl_q[`F_WIDTH_HI:`F_WIDTH_LO], half);
    assign wmask = ~({WORD_W{1'b1}} << wid);
    assign rx_rst_n = rst_n & ~rx_reset;
    assign tx_rst_n = rst_n & ~tx_reset;

    // apb slave with one wait state; write lands on the completing edge
    assign apb_acc = psel & penable & ~pready_q;
    assign apb_done = psel & penable & pready_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= apb_acc;
            pslverr_q <= apb_acc && decode(paddr) == SEL_NONE;
            if (apb_acc) begin
                if (decode(paddr) == SEL_CTRL) begin
                    prdata_q <= ctrl_q;
                end else if (decode(paddr) == SEL_STAT) begin
                    prdata_q <= 32'h0000_0000;
                    prdata_q[`S_LOCKED] <= locked_q;
                    prdata_q[`S_EMPTY] <= empty_q;
                    prdata_q[`S_LEVEL_LO +: PW + 1] <= lvl_q;
                    prdata_q[`S_OVERFLOW] <= ovf_q;
                    prdata_q[`S_TAP_LO +: TW] <= tap_q;
                end else begin
                    prdata_q <= 32'h0000_0000;
                end
            end
        end
    end

    // control register and sticky overflow; a new overflow beats the clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= `CTRL_RESET;
            ovf_q <= 1'b0;
        end else begin
            if (apb_done && pwrite && decode(paddr) == SEL_CTRL) begin
                ctrl_q <= pwdata;
            end
            if (ovf_evt) begin
                ovf_q <= 1'b1;
            end else if (apb_done && pwrite && decode(paddr) == SEL_STAT
                         && pwdata[`S_OVERFLOW]) begin
                ovf_q <= 1'b0;
            end
        end
    end

    // pad synchroniser; a level counts once stages two and three agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= 2'h0;
            s2_q <= 2'h0;
            s3_q <= 2'h0;
            pad_q <= 2'h0;
        end else begin
            s1_q <= rx_pad_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            pad_q <= (pad_q & (s2_q ^ s3_q)) | (s3_q & ~(s2_q ^ s3_q));
        end
    end
    assign rx_bit = pad_q & {2{ctrl_q[`F_BUF_EN]}};

    // per-lane delay chain; lane 0 is the rising-edge bit, lane 1 the falling
    for (genvar l = 0; l < 2; l++) begin : g_delay
        logic [DELAY_TAPS-1:0] hist_q;
        always_ff @(posedge clk or negedge rx_rst_n) begin
            if (!rx_rst_n) begin
                hist_q <= '0;
            end else begin
                hist_q <= {hist_q[DELAY_TAPS-2:0], rx_bit[l]};
            end
        end
        assign dly_bit[l] = hist_q[tap_q];
    end

    // deserializer: one bit per clock at full rate, two at half rate
    always_comb begin
        rx_sh_d = rx_sh_q;
        {rx_tick, rx_cnt_d} = advance(rx_cnt_q, wid, half);
        rx_sh_d[rx_cnt_q] = dly_bit[0];
        if (half) begin
            rx_sh_d[4'(rx_cnt_q + 4'h1)] = dly_bit[1];
        end
        rx_word = rx_sh_d & wmask;
    end

    always_ff @(posedge clk or negedge rx_rst_n) begin
        if (!rx_rst_n) begin
            rx_sh_q <= '0;
            rx_cnt_q <= 4'h0;
        end else begin
            rx_sh_q <= rx_sh_d;
            rx_cnt_q <= rx_cnt_d;
        end
    end

    // sweep bookkeeping: taps where the word repeats form the open window
    assign stable = (rx_word == prev_q);
    assign found_n = found_q | stable;
    assign lo_n = (stable && !found_q) ? tap_q : lo_q;
    assign hi_n = stable ? tap_q : hi_q;
    assign mid_sum = {1'b0, lo_n} + {1'b0, hi_n};

    // delay control and phase aligner, sampled at each word boundary
    always_ff @(posedge clk or negedge rx_rst_n) begin
        if (!rx_rst_n) begin
            tap_q <= '0;
            al_state_q <= AL_IDLE;
            locked_q <= 1'b0;
            found_q <= 1'b0;
            lo_q <= '0;
            hi_q <= '0;
            prev_q <= '0;
        end else if (rx_tick) begin
            if (delay_adjust_reset) begin
                tap_q <= '0;
                al_state_q <= AL_IDLE;
                locked_q <= 1'b0;
            end else if (!ctrl_q[`F_ALIGN_EN]) begin
                al_state_q <= AL_IDLE;
                locked_q <= 1'b0;
                if (delay_adjust_enable) begin
                    if (delay_direction && tap_q != TAP_MAX) begin
                        tap_q <= tap_q + 1'b1;
                    end else if (!delay_direction && tap_q != '0) begin
                        tap_q <= tap_q - 1'b1;
                    end
                end
            end else begin
                case (al_state_q)
                    AL_IDLE: begin
                        if (delay_adjust_enable) begin
                            al_state_q <= AL_SWEEP;
                            tap_q <= '0;
                            found_q <= 1'b0;
                            prev_q <= rx_word;
                        end
                    end
                    AL_SWEEP: begin
                        found_q <= found_n;
                        lo_q <= lo_n;
                        hi_q <= hi_n;
                        prev_q <= rx_word;
                        if (tap_q == TAP_MAX) begin
                            tap_q <= found_n ? mid_sum[TW:1] : '0;
                            al_state_q <= AL_LOCKED;
                            locked_q <= 1'b1;
                        end else begin
                            tap_q <= tap_q + 1'b1;
                        end
                    end
                    AL_LOCKED: begin
                        locked_q <= 1'b1;
                    end
                    default: begin
                        al_state_q <= AL_IDLE;
                    end
                endcase
            end
        end
    end

    // receive fifo bookkeeping; a pop on empty is ignored
    assign push = rx_tick & ctrl_q[`F_RX_EN] & ctrl_q[`F_FIFO_EN];
    assign pop = fifo_read_enable & ctrl_q[`F_FIFO_EN] & (lvl_q != '0);
    assign push_ok = push & ((lvl_q != FIFO_FULL) | pop);
    assign ovf_evt = push & ~push_ok;
    always_comb begin
        lvl_d = lvl_q;
        if (push_ok && !pop) begin
            lvl_d = lvl_q + 1'b1;
        end else if (pop && !push_ok) begin
            lvl_d = lvl_q - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rx_rst_n) begin
        if (!rx_rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
            lvl_q <= '0;
            empty_q <= 1'b1;
        end else begin
            if (push_ok) begin
                mem[wr_q] <= rx_word;
                wr_q <= (wr_q == PW'(FIFO_DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == PW'(FIFO_DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
            lvl_q <= lvl_d;
            empty_q <= (lvl_d == '0);
        end
    end

    // parallel receive output: direct at the word boundary, or from the fifo
    always_ff @(posedge clk or negedge rx_rst_n) begin
        if (!rx_rst_n) begin
            rx_data_q <= '0;
            rx_valid_q <= 1'b0;
        end else if (ctrl_q[`F_FIFO_EN]) begin
            rx_valid_q <= pop;
            if (pop) begin
                rx_data_q <= mem[rd_q];
            end
        end else begin
            rx_valid_q <= rx_tick & ctrl_q[`F_RX_EN];
            if (rx_tick && ctrl_q[`F_RX_EN]) begin
                rx_data_q <= rx_word;
            end
        end
    end

    // serializer: next word or clock pattern is taken at each word boundary
    assign refpat = ~({WORD_W{1'b1}} << (wid >> 1));
    always_comb begin
        {tx_tick, tx_cnt_d} = advance(tx_cnt_q, wid, half);
        tx_bits[0] = tx_hold_q[tx_cnt_q];
        tx_bits[1] = half ? tx_hold_q[4'(tx_cnt_q + 4'h1)] : tx_bits[0];
    end

    always_ff @(posedge clk or negedge tx_rst_n) begin
        if (!tx_rst_n) begin
            tx_cnt_q <= 4'h0;
            tx_hold_q <= '0;
            tx_taken_q <= 1'b0;
            tx_pad_q <= 2'h0;
        end else begin
            tx_cnt_q <= tx_cnt_d;
            tx_taken_q <= tx_tick & ctrl_q[`F_TX_EN];
            if (tx_tick) begin
                tx_hold_q <= ctrl_q[`F_TX_REFCLK] ? refpat : tx_data_in & wmask;
            end
            tx_pad_q <= ctrl_q[`F_TX_EN] ? tx_bits : 2'h0;
        end
    end

    // pad-side controls: output enable, buffer, termination, bypass
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_oe_q <= 1'b0;
            buf_on_q <= 1'b0;
            term_on_q <= 1'b0;
            bypass_q <= 1'b0;
        end else begin
            tx_oe_q <= ctrl_q[`F_TX_EN] & ctrl_q[`F_TX_OE];
            buf_on_q <= ctrl_q[`F_BUF_EN];
            term_on_q <= ctrl_q[`F_TERM_DYN] ? ctrl_q[`F_TERM_EN] : ctrl_q[`F_TERM_STATIC];
            bypass_q <= ctrl_q[`F_BYPASS] && wid == 4'h1 && rx_bit[0];
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign tx_pad_out = tx_pad_q;
    assign tx_pad_oe = tx_oe_q;
    assign bypass_input = bypass_q;
    assign rx_buffer_on = buf_on_q;
    assign termination_on = term_on_q;
    assign rx_data_out = rx_data_q;
    assign rx_word_valid = rx_valid_q;
    assign fifo_empty_flag = empty_q;
    assign align_locked = locked_q;
    assign tx_word_taken = tx_taken_q;

    // checks on the lane's own behaviour
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n || rx_reset || tx_reset);

    sequence s_pop_req;
        fifo_read_enable && ctrl_q[`F_FIFO_EN] && !empty_q;
    endsequence
    sequence s_word_out;
        ##1 rx_word_valid && rx_data_out == $past(mem[rd_q]);
    endsequence
    property p_fifo_pop;
        s_pop_req |-> s_word_out;
    endproperty
    a_fifo_pop: assert property (p_fifo_pop) else $error("pop did not present word");
    property p_empty_flag;
        fifo_empty_flag == (lvl_q == '0);
    endproperty
    a_empty_flag: assert property (p_empty_flag) else $error("empty flag wrong");
    property p_pop_empty;
        fifo_read_enable && ctrl_q[`F_FIFO_EN] && empty_q && !push
            |=> $stable(rx_data_out) && !rx_word_valid && empty_q;
    endproperty
    a_pop_empty: assert property (p_pop_empty) else $error("read on empty changed state");
    property p_delay_up;
        rx_tick && !ctrl_q[`F_ALIGN_EN] && delay_adjust_enable && delay_direction
            && !delay_adjust_reset && tap_q != TAP_MAX |=> tap_q == $past(tap_q) + 1'b1;
    endproperty
    a_delay_up: assert property (p_delay_up) else $error("delay did not step up");
    property p_delay_rst;
        rx_tick && delay_adjust_reset |=> tap_q == '0 && !align_locked;
    endproperty
    a_delay_rst: assert property (p_delay_rst) else $error("adjust reset ignored");
    property p_lock_rise;
        $rose(align_locked) |-> $past(al_state_q) == AL_SWEEP && $past(tap_q) == TAP_MAX;
    endproperty
    a_lock_rise: assert property (p_lock_rise) else $error("lock without full sweep");
    property p_oe;
        tx_pad_oe |-> $past(ctrl_q[`F_TX_EN]) && $past(ctrl_q[`F_TX_OE]);
    endproperty
    a_oe: assert property (p_oe) else $error("pad driven without enable");
    property p_term;
        ctrl_q[`F_TERM_DYN] ##1 ctrl_q[`F_TERM_DYN] |-> termination_on == $past(ctrl_q[`F_TERM_EN]);
    endproperty
    a_term: assert property (p_term) else $error("termination not following enable");
    property p_bypass;
        bypass_input |-> $past(wid) == 4'h1 && $past(ctrl_q[`F_BYPASS]);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass outside width one");
    property p_direct_word;
        rx_tick && ctrl_q[`F_RX_EN] && !ctrl_q[`F_FIFO_EN] |=> rx_word_valid
            && rx_data_out == $past(rx_word);
    endproperty
    a_direct_word: assert property (p_direct_word) else $error("word not presented");
endmodule : lvds_serdes_lane
`default_nettype wire

// ===== rtl/lane_cfg.svh
// register offsets, field positions, reset values and limits of the lane
`ifndef LANE_CFG_SVH
`define LANE_CFG_SVH
`define LANE_CTRL_OFS 8'h00
`define LANE_STAT_OFS 8'h04
`define CTRL_RESET 32'h0000_0440
`define F_RX_EN 0
`define F_TX_EN 1
`define F_HALF 2
`define F_WIDTH_LO 3
`define F_WIDTH_HI 6
`define F_FIFO_EN 7
`define F_ALIGN_EN 8
`define F_TX_REFCLK 9
`define F_BUF_EN 10
`define F_TERM_DYN 11
`define F_TERM_EN 12
`define F_TX_OE 13
`define F_BYPASS 14
`define F_TERM_STATIC 15
`define S_LOCKED 0
`define S_EMPTY 1
`define S_LEVEL_LO 2
`define S_OVERFLOW 6
`define S_TAP_LO 7
`define WORD_MAX 4'ha
`endif

// ===== rtl/lane_pkg.sv
// types shared by the lane design
package lane_pkg;
    typedef enum logic [1:0] {AL_IDLE, AL_SWEEP, AL_LOCKED} align_state_t;
    typedef enum logic [1:0] {SEL_CTRL, SEL_STAT, SEL_NONE} reg_sel_t;
endpackage : lane_pkg

// ===== test/link_partner.sv
// link partner model: drives the receive pad and captures the transmit pad
`timescale 1ns/100ps
`default_nettype none
module link_partner (
    input wire logic clk,
    input wire logic line_bit,
    output logic [1:0] rx_pad_in,
    input wire logic [1:0] tx_pad_out,
    input wire logic tx_pad_oe,
    output logic [9:0] cap,
    output logic [9:0] cap_half
);
    // both half-rate slots carry one level; same width in both directions
    assign rx_pad_in = {line_bit, line_bit};
    // one bit per clock while the pad is driven, first bit lands in cap[0]
    always_ff @(posedge clk) begin
        if (tx_pad_oe) begin
            cap <= {tx_pad_out[0], cap[9:1]};
        end
    end
    // half rate: two bits per clock, lane 0 carries the earlier bit
    always_ff @(posedge clk) begin
        if (tx_pad_oe) begin
            cap_half <= {tx_pad_out, cap_half[9:2]};
        end
    end
endmodule : link_partner
`default_nettype wire

// ===== test/tb.sv
// testbench: apb access tasks and lane scenarios against the link partner
`timescale 1ns/100ps
`default_nettype none
`include "lane_cfg.svh"
module tb;
    import lane_pkg::*;
    logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, line_bit = 1;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, q, base;
    logic pready, pslverr, e, tx_pad_oe, bypass_input, rx_buffer_on, termination_on;
    logic rx_reset = 0, tx_reset = 0, fifo_read_enable = 0;
    logic delay_adjust_enable = 0, delay_direction = 0, delay_adjust_reset = 0;
    logic [1:0] rx_pad_in, tx_pad_out;
    logic [9:0] rx_data_out, tx_data_in = 10'h2d3, cap, cap_half;
    logic rx_word_valid, fifo_empty_flag, align_locked, tx_word_taken;
    int error_cnt = 0, comparisons = 0, cycles = 0;

    lvds_serdes_lane u_dut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .rx_pad_in, .tx_pad_out, .tx_pad_oe, .bypass_input,
        .rx_buffer_on, .termination_on, .rx_reset, .tx_reset, .delay_adjust_enable,
        .delay_direction, .delay_adjust_reset, .fifo_read_enable, .rx_data_out,
        .rx_word_valid, .fifo_empty_flag, .align_locked, .tx_data_in, .tx_word_taken);
    link_partner u_partner (.clk, .line_bit, .rx_pad_in, .tx_pad_out, .tx_pad_oe, .cap,
        .cap_half);

    // clock at 250 MHz
    always #2 clk = ~clk;

    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            conclude();
        end
    end

    function automatic logic [31:0] b(input int p);
        return 32'h0000_0001 << p;
    endfunction : b

    task automatic conclude();
        $display("counts: %0d comparisons, %0d mismatches", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude

    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        comparisons++;
        if (g !== x) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", n, x, g);
        end
    endtask : chk

    // one apb transfer: setup, access held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic err);
        @(posedge clk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic err;
        apb(1'b1, a, d, r, err);
    endtask : wr

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wt

    // drive the delay controls and hold them for n cycles
    task automatic adj(input logic en, input logic dir, input logic rs, input int n);
        @(posedge clk);
        delay_adjust_enable <= en;
        delay_direction <= dir;
        delay_adjust_reset <= rs;
        repeat (n) @(posedge clk);
        #1;
    endtask : adj

    task automatic tap(input logic [31:0] x);
        apb(1'b0, `LANE_STAT_OFS, 32'h0000_0000, q, e);
        chk("delay tap", x, (q >> `S_TAP_LO) & 32'h0000_000f);
    endtask : tap

    // wait for a taken word, then n cycles for its bits; h picks the two-lane capture
    task automatic txword(input logic [9:0] x, input int n, input logic h);
        wt(12);
        for (int i = 0; i < 40 && tx_word_taken !== 1'b1; i++) begin
            wt(1);
        end
        wt(n);
        chk("tx word", {22'h0, x}, {22'h0, h ? cap_half : cap});
    endtask : txword

    // pop one word and look at it in the answer cycle
    task automatic pop(input logic v);
        @(posedge clk);
        fifo_read_enable <= 1;
        @(posedge clk);
        fifo_read_enable <= 0;
        #1;
        chk("rx valid", {31'h0, v}, {31'h0, rx_word_valid});
        chk("rx word", 32'h0000_03ff, {22'h0, rx_data_out});
    endtask : pop

    initial begin
        base = b(`F_RX_EN) | b(`F_TX_EN) | b(`F_BUF_EN) | b(`F_TERM_DYN) | b(`F_TERM_EN)
            | b(`F_TX_OE) | (32'h0000_000a << `F_WIDTH_LO);
        repeat (3) @(posedge clk);
        rst_n <= 1;
        apb(1'b0, `LANE_CTRL_OFS, 32'h0000_0000, q, e);
        chk("ctrl reset", `CTRL_RESET, q);
        apb(1'b0, `LANE_STAT_OFS, 32'h0000_0000, q, e);
        chk("status reset", b(`S_EMPTY), q);
        apb(1'b0, 8'h08, 32'h0000_0000, q, e);
        chk("unmapped err", 32'h0000_0001, {31'h0, e});
        chk("unmapped data", 32'h0000_0000, q);
        $display("test reset done");

        wr(`LANE_CTRL_OFS, base);
        wt(2);
        chk("pad oe", 32'h0000_0001, {31'h0, tx_pad_oe});
        chk("buffer on", 32'h0000_0001, {31'h0, rx_buffer_on});
        chk("term on", 32'h0000_0001, {31'h0, termination_on});
        txword(10'h2d3, 11, 1'b0);
        wr(`LANE_CTRL_OFS, base | b(`F_TX_REFCLK));
        txword(10'h01f, 11, 1'b0);
        wr(`LANE_CTRL_OFS, base | b(`F_HALF));
        txword(10'h2d3, 6, 1'b1);
        wr(`LANE_CTRL_OFS, base & ~(b(`F_TX_OE) | b(`F_BUF_EN) | b(`F_TERM_EN)));
        wt(2);
        chk("pad oe off", 32'h0000_0000, {31'h0, tx_pad_oe});
        chk("buffer off", 32'h0000_0000, {31'h0, rx_buffer_on});
        chk("term off", 32'h0000_0000, {31'h0, termination_on});
        $display("test pins and transmit done");

        wr(`LANE_CTRL_OFS, base);
        wt(30);
        wr(`LANE_CTRL_OFS, base | b(`F_FIFO_EN));
        wt(150);
        apb(1'b0, `LANE_STAT_OFS, 32'h0000_0000, q, e);
        chk("fifo full", b(`S_OVERFLOW) | (32'h0000_0008 << `S_LEVEL_LO), q);
        wr(`LANE_CTRL_OFS, (base & ~b(`F_RX_EN)) | b(`F_FIFO_EN));
        wt(20);
        wr(`LANE_STAT_OFS, b(`S_OVERFLOW));
        repeat (8) pop(1'b1);
        chk("empty flag", 32'h0000_0001, {31'h0, fifo_empty_flag});
        pop(1'b0);
        apb(1'b0, `LANE_STAT_OFS, 32'h0000_0000, q, e);
        chk("fifo drained", b(`S_EMPTY), q);
        $display("test fifo done");

        wr(`LANE_CTRL_OFS, base);
        adj(1'b1, 1'b1, 1'b0, 250);
        tap(32'h0000_000f);
        adj(1'b1, 1'b0, 1'b0, 250);
        tap(32'h0000_0000);
        adj(1'b1, 1'b1, 1'b0, 250);
        adj(1'b0, 1'b0, 1'b1, 30);
        tap(32'h0000_0000);
        adj(1'b0, 1'b0, 1'b0, 10);
        wr(`LANE_CTRL_OFS, base | b(`F_ALIGN_EN));
        adj(1'b1, 1'b0, 1'b0, 30);
        adj(1'b0, 1'b0, 1'b0, 250);
        chk("locked", 32'h0000_0001, {31'h0, align_locked});
        adj(1'b0, 1'b0, 1'b1, 30);
        chk("lock dropped", 32'h0000_0000, {31'h0, align_locked});
        adj(1'b0, 1'b0, 1'b0, 10);
        $display("test delay and aligner done");

        wr(`LANE_CTRL_OFS, base | b(`F_FIFO_EN));
        wt(60);
        chk("fifo filling", 32'h0000_0000, {31'h0, fifo_empty_flag});
        @(posedge clk);
        rx_reset <= 1;
        @(posedge clk);
        rx_reset <= 0;
        #1;
        chk("rx reset empty", 32'h0000_0001, {31'h0, fifo_empty_flag});
        $display("test receive reset done");

        wr(`LANE_CTRL_OFS, b(`F_RX_EN) | b(`F_BUF_EN) | b(`F_BYPASS) | b(`F_WIDTH_LO));
        wt(10);
        chk("bypass high", 32'h0000_0001, {31'h0, bypass_input});
        @(posedge clk);
        line_bit <= 0;
        wt(10);
        chk("bypass low", 32'h0000_0000, {31'h0, bypass_input});
        @(posedge clk);
        line_bit <= 1;
        wr(`LANE_CTRL_OFS, base | b(`F_BYPASS));
        wt(10);
        chk("bypass wide", 32'h0000_0000, {31'h0, bypass_input});
        $display("test bypass done");
        conclude();
    end
endmodule : tb
`default_nettype wire
